// ==== status_pkg.sv ====
// Package: offsets, bit positions, reset values and op codes for the status block
package status_pkg;

	localparam logic [7:0] STATUS_OFFSET   = 8'h03;
	localparam logic [7:0] STATUS_ADDR_MSK = 8'h7F;
	localparam int         BIT_CARRY       = 0;
	localparam int         BIT_DIGIT       = 1;
	localparam int         BIT_ZERO        = 2;
	localparam int         BIT_SLEEP       = 3;
	localparam int         BIT_WDOG        = 4;
	localparam int         BIT_PAGE_LO     = 5;
	localparam int         BIT_PAGE_HI     = 6;
	localparam int         BIT_IND_PAGE    = 7;
	localparam logic [7:0] STATUS_RESET    = 8'h18;
	localparam logic [7:0] WRITE_MASK      = 8'hE7;
	localparam logic [7:0] FLAG_MASK       = 8'h07;
	localparam logic [7:0] WIPE_KEEP_MASK  = 8'h1B;
	localparam logic [7:0] WIPE_SET        = 8'h04;

	typedef enum logic [3:0] {
		OP_NONE    = 4'h0,
		OP_ADD     = 4'h1,
		OP_SUB     = 4'h2,
		OP_ROT_RIGHT = 4'h3,
		OP_ROT_LEFT  = 4'h4,
		OP_WIPE    = 4'h5,
		OP_LOGIC   = 4'h6,
		OP_MOVE    = 4'h7,
		OP_BITCLR  = 4'h8,
		OP_BITSET  = 4'h9,
		OP_SWAP    = 4'hA,
		OP_STORE   = 4'hB
	} alu_op_e;

	typedef struct packed {
		alu_op_e    op;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] dest_addr;
		logic       dest_wr;
		logic [7:0] wr_data;
	} instr_s;

	typedef struct packed {
		logic [7:0] result;
		logic       zero;
		logic       digit;
		logic       carry;
		logic       upd_z;
		logic       upd_dc_c;
	} flags_s;

endpackage : status_pkg

// ==== flag_alu.sv ====
// Flag logic: result and arithmetic flags for one instruction
module flag_alu (
	input  wire status_pkg::instr_s instr_i,
	input  wire logic [0:0]         carry_in_i,
	output status_pkg::flags_s      flags_o
);

	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] opb;

	always_comb begin
		opb = (instr_i.op == status_pkg::OP_SUB) ? ~instr_i.b : instr_i.b;
		// Two's complement add; carry out is the inverted borrow
		sum = {1'b0, instr_i.a} + {1'b0, opb} +
			{8'h00, (instr_i.op == status_pkg::OP_SUB)};
		nib = {1'b0, instr_i.a[3:0]} + {1'b0, opb[3:0]} +
			{4'h0, (instr_i.op == status_pkg::OP_SUB)};
		flags_o = '0;
		case (instr_i.op)
			status_pkg::OP_ADD, status_pkg::OP_SUB: begin
				flags_o.result   = sum[7:0];
				flags_o.digit    = nib[4];
				flags_o.carry    = sum[8];
				flags_o.upd_z    = 1'b1;
				flags_o.upd_dc_c = 1'b1;
			end
			status_pkg::OP_ROT_RIGHT: begin
				flags_o.result   = {carry_in_i, instr_i.a[7:1]};
				flags_o.carry    = instr_i.a[0];
				flags_o.upd_dc_c = 1'b1;
			end
			status_pkg::OP_ROT_LEFT: begin
				flags_o.result   = {instr_i.a[6:0], carry_in_i};
				flags_o.carry    = instr_i.a[7];
				flags_o.upd_dc_c = 1'b1;
			end
			status_pkg::OP_LOGIC, status_pkg::OP_MOVE: begin
				flags_o.result = instr_i.wr_data;
				flags_o.upd_z  = 1'b1;
			end
			default: begin
				flags_o.result = instr_i.wr_data;
			end
		endcase
		flags_o.zero = (flags_o.result == 8'h00);
	end

endmodule : flag_alu

// ==== event_flags.sv ====
// Watchdog-expiry and sleep-entered flag next-state logic
module event_flags (
	input  wire logic wdog_flag_i,
	input  wire logic sleep_flag_i,
	input  wire logic kick_i,
	input  wire logic sleep_i,
	input  wire logic timeout_i,
	output logic      wdog_next_o,
	output logic      sleep_next_o
);

	// Only device events move these bits; writes never reach them
	always_comb begin
		wdog_next_o = wdog_flag_i;
		if (timeout_i) begin
			wdog_next_o = 1'b0;
		end else if (kick_i || sleep_i) begin
			wdog_next_o = 1'b1;
		end
		sleep_next_o = sleep_flag_i;
		if (sleep_i) begin
			sleep_next_o = 1'b0;
		end else if (kick_i) begin
			sleep_next_o = 1'b1;
		end
	end

endmodule : event_flags

// ==== cpu_status_flag_register.sv ====
// Status register of the core: arithmetic flags, reset cause, page select
// Function
// - The status register is a legal destination for any instruction.
// - Flag-updating ops writing the register lose their write to bits 2..0.
// - Watchdog-expiry and sleep-entered bits ignore all writes.
// - Wiping the register clears bits 7..5, sets Z, keeps 4, 3, 1, 0.
// - Bit clear, bit set, nibble swap and store leave bits 2..0 alone unless they write the register.
// - Subtract adds the two's complement; C and DC are inverted borrow.
// - Bit 1 takes the carry out of result bit 3 on add and subtract.
// - Bit 0 takes the carry out of result bit 7 on add and subtract.
// - Rotates load C with the bit shifted out of the source.
// - Bit 4 is 1 after reset, kick or sleep, 0 after watchdog time-out.
// - Bits 6..5 select one of four 128-byte direct pages, reset 0.
module cpu_status_flag_register (
	input  wire  logic               mclk_i,
	input  wire  logic               reset_n_i,
	input  wire  status_pkg::instr_s instr_i,
	input  wire  logic               instr_valid_i,
	input  wire  logic               kick_i,
	input  wire  logic               sleep_i,
	input  wire  logic               timeout_i,
	input  wire  logic [7:0]         addr_i,
	input  wire  logic [7:0]         wdata_i,
	input  wire  logic               wr_i,
	input  wire  logic               rd_i,
	output logic [7:0]               rdata_o,
	output logic [7:0]               status_o,
	output logic [7:0]               result_o,
	output logic [1:0]               direct_page_o,
	output logic                     indirect_page_o
);

	// ==========================================================
	// Flag logic and event flags
	logic [7:0]         core_flags_and_page_select_reg;
	logic [7:0]         core_flags_and_page_select_next;
	logic [7:0]         rdata_reg;
	logic [7:0]         rdata_next;
	logic [7:0]         result_reg;
	logic [7:0]         result_next;
	status_pkg::flags_s flags;
	logic               wdog_next;
	logic               sleep_next;
	logic               hit_instr;
	logic               hit_bus;
	logic [7:0]         val;

	flag_alu u_flag_alu (
		.instr_i    (instr_i),
		.carry_in_i (core_flags_and_page_select_reg[status_pkg::BIT_CARRY]),
		.flags_o    (flags)
	);

	event_flags u_event_flags (
		.wdog_flag_i  (core_flags_and_page_select_reg[status_pkg::BIT_WDOG]),
		.sleep_flag_i (core_flags_and_page_select_reg[status_pkg::BIT_SLEEP]),
		.kick_i       (kick_i),
		.sleep_i      (sleep_i),
		.timeout_i    (timeout_i),
		.wdog_next_o  (wdog_next),
		.sleep_next_o (sleep_next)
	);

	// ==========================================================
	// Next status value
	always_comb begin
		hit_instr = instr_valid_i && instr_i.dest_wr &&
			((instr_i.dest_addr & status_pkg::STATUS_ADDR_MSK) ==
			status_pkg::STATUS_OFFSET);
		hit_bus = wr_i && (addr_i == status_pkg::STATUS_OFFSET);
		val = core_flags_and_page_select_reg;
		result_next = result_reg;
		if (instr_valid_i) begin
			result_next = flags.result;
			if (flags.upd_z) begin
				val[status_pkg::BIT_ZERO] = flags.zero;
			end
			if (flags.upd_dc_c) begin
				val[status_pkg::BIT_CARRY] = flags.carry;
			end
			if (flags.upd_dc_c && (instr_i.op == status_pkg::OP_ADD ||
				instr_i.op == status_pkg::OP_SUB)) begin
				val[status_pkg::BIT_DIGIT] = flags.digit;
			end
		end
		if (hit_instr) begin
			if (instr_i.op == status_pkg::OP_WIPE) begin
				val = (val & status_pkg::WIPE_KEEP_MASK) |
					status_pkg::WIPE_SET;
			end else if (flags.upd_z || flags.upd_dc_c) begin
				// Flag bits keep the flag logic's values
				val = (val & ~(status_pkg::WRITE_MASK & ~status_pkg::FLAG_MASK)) |
					(flags.result & status_pkg::WRITE_MASK &
					~status_pkg::FLAG_MASK);
			end else begin
				// Non-flag ops write all writable bits
				val = (val & ~status_pkg::WRITE_MASK) |
					(flags.result & status_pkg::WRITE_MASK);
			end
		end else if (hit_bus) begin
			val = (val & ~status_pkg::WRITE_MASK) |
				(wdata_i & status_pkg::WRITE_MASK);
		end
		// Event bits last: writes never reach them
		val[status_pkg::BIT_WDOG]  = wdog_next;
		val[status_pkg::BIT_SLEEP] = sleep_next;
		core_flags_and_page_select_next = val;
		rdata_next = 8'h00;
		if (rd_i && addr_i == status_pkg::STATUS_OFFSET) begin
			rdata_next = core_flags_and_page_select_reg;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			core_flags_and_page_select_reg <= status_pkg::STATUS_RESET;
			rdata_reg                      <= 8'h00;
			result_reg                     <= 8'h00;
		end else begin
			core_flags_and_page_select_reg <= core_flags_and_page_select_next;
			rdata_reg                      <= rdata_next;
			result_reg                     <= result_next;
		end
	end

	assign rdata_o         = rdata_reg;
	assign status_o        = core_flags_and_page_select_reg;
	assign result_o        = result_reg;
	// Page selects come straight from the register bits
	assign direct_page_o   = core_flags_and_page_select_reg[6:5];
	assign indirect_page_o = core_flags_and_page_select_reg[7];

endmodule : cpu_status_flag_register

// ==== status_sva.sv ====
// Checker: port timing relations of the status register block
module status_sva (
	input wire logic               mclk_i,
	input wire logic               reset_n_i,
	input wire status_pkg::instr_s instr_i,
	input wire logic               instr_valid_i,
	input wire logic               kick_i,
	input wire logic               sleep_i,
	input wire logic               timeout_i,
	input wire logic [7:0]         addr_i,
	input wire logic [7:0]         wdata_i,
	input wire logic               wr_i,
	input wire logic               rd_i,
	input wire logic [7:0]         rdata_o,
	input wire logic [7:0]         status_o,
	input wire logic [1:0]         direct_page_o,
	input wire logic               indirect_page_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	logic quiet;
	logic to_st;
	logic [8:0] add_sum;
	assign quiet = !kick_i && !sleep_i && !timeout_i;
	assign add_sum = {1'b0, instr_i.a} + {1'b0, instr_i.b};
	assign to_st = instr_valid_i && instr_i.dest_wr
		&& (instr_i.dest_addr & 8'h7F) == 8'h03;
	// ==========================================
	// Assertions
	a_read_data: assert property (rd_i && addr_i == 8'h03
		|=> rdata_o == $past(status_o)) else $error("read data wrong");
	a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not idle");
	a_timeout_clr: assert property (timeout_i |=> !status_o[4])
		else $error("expiry bit not cleared");
	a_add_carry: assert property (instr_valid_i && !to_st
		&& instr_i.op == status_pkg::OP_ADD
		|=> status_o[0] == $past(add_sum[8])) else $error("add carry wrong");
	a_kick_bits: assert property (kick_i && !sleep_i && !timeout_i
		|=> status_o[4:3] == 2'b11) else $error("kick bits wrong");
	a_sleep_clr: assert property (sleep_i && !timeout_i
		|=> status_o[4:3] == 2'b10) else $error("sleep bits wrong");
	a_event_hold: assert property (quiet |=> $stable(status_o[4:3]))
		else $error("event bits changed");
	a_page_map: assert property (direct_page_o == status_o[6:5]
		&& indirect_page_o == status_o[7]) else $error("page outputs wrong");
	a_wipe_bits: assert property (to_st && instr_i.op == status_pkg::OP_WIPE
		|=> status_o[7:5] == 3'h0 && status_o[2]
		&& status_o[1:0] == $past(status_o[1:0])) else $error("wipe wrong");
	a_bus_write: assert property (wr_i && addr_i == 8'h03 && !instr_valid_i
		&& quiet |=> status_o == (($past(wdata_i) & 8'hE7)
		| ($past(status_o) & 8'h18))) else $error("bus write wrong");
	a_flag_keep: assert property (instr_valid_i && !to_st && !wr_i
		&& instr_i.op inside {status_pkg::OP_STORE, status_pkg::OP_SWAP}
		|=> status_o[2:0] == $past(status_o[2:0])) else $error("flags moved");
	c_timeout: cover property (timeout_i);
	c_wipe: cover property (to_st && instr_i.op == status_pkg::OP_WIPE);
	c_read: cover property (rd_i && addr_i == 8'h03);
endmodule : status_sva

bind cpu_status_flag_register status_sva i_status_sva (.*);

// ==== tb.sv ====
// Testbench: status register flags, events, bus access and paging
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		status_pkg::alu_op_e op;
		logic [7:0]          a;
		logic [7:0]          b;
		logic [7:0]          r;
		logic [2:0]          f;
		logic [2:0]          m;
		logic                rm;
	} row_s;
	logic               mclk_i = 0, reset_n_i = 0, instr_valid_i = 0;
	logic               kick_i = 0, sleep_i = 0, timeout_i = 0;
	logic               wr_i = 0, rd_i = 0;
	status_pkg::instr_s instr_i = '0;
	logic [7:0]         addr_i = 0, wdata_i = 0, rdata_o, status_o, result_o;
	logic [1:0]         direct_page_o;
	logic               indirect_page_o;
	int                 bad_count = 0, n_checks = 0;
	row_s rows[10] = '{
		'{status_pkg::OP_ADD, 8'h01, 8'h02, 8'h03, 3'h0, 3'h7, 1'b1},
		'{status_pkg::OP_ADD, 8'h0F, 8'h01, 8'h10, 3'h2, 3'h7, 1'b1},
		'{status_pkg::OP_ADD, 8'hFF, 8'h01, 8'h00, 3'h7, 3'h7, 1'b1},
		'{status_pkg::OP_ADD, 8'h80, 8'h80, 8'h00, 3'h5, 3'h7, 1'b1},
		'{status_pkg::OP_SUB, 8'h05, 8'h05, 8'h00, 3'h7, 3'h7, 1'b1},
		'{status_pkg::OP_ROT_RIGHT, 8'h01, 8'h01, 8'h00, 3'h1, 3'h1, 1'b0},
		'{status_pkg::OP_ROT_LEFT, 8'h7E, 8'h7E, 8'h00, 3'h0, 3'h1, 1'b0},
		'{status_pkg::OP_ROT_LEFT, 8'h80, 8'h80, 8'h00, 3'h1, 3'h1, 1'b0},
		'{status_pkg::OP_ROT_RIGHT, 8'h02, 8'h02, 8'h00, 3'h0, 3'h1, 1'b0},
		'{status_pkg::OP_STORE, 8'h55, 8'h55, 8'h00, 3'h6, 3'h7, 1'b0}};
	always #5 mclk_i = ~mclk_i;
	cpu_status_flag_register i_cpu_status_flag_register (.*);
	// ==========================================
	// Tasks
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task ins(input status_pkg::alu_op_e o, input logic [7:0] a, b,
		input logic d);
		@(posedge mclk_i);
		instr_valid_i <= 1;
		instr_i <= '{o, a, b, d ? 8'h03 : 8'h20, 1'b1, a};
		@(posedge mclk_i);
		instr_valid_i <= 0;
		#1;
	endtask : ins
	task bus(input logic w, input logic [7:0] a, d);
		@(posedge mclk_i);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 0;
		rd_i <= 0;
		#1;
	endtask : bus
	task ev(input logic k, s, t);
		@(posedge mclk_i);
		{kick_i, sleep_i, timeout_i} <= {k, s, t};
		@(posedge mclk_i);
		{kick_i, sleep_i, timeout_i} <= 3'h0;
		#1;
	endtask : ev
	task results;
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	// ==========================================
	// Sequence
	initial begin
		#100us;
		bad_count++;
		results();
	end
	initial begin
		repeat (2) @(posedge mclk_i);
		reset_n_i <= 1;
		#1;
		chk("reset status", 8'h18, status_o);
		foreach (rows[i]) begin
			ins(rows[i].op, rows[i].a, rows[i].b, 1'b0);
			chk("flags", {5'h00, rows[i].f}, status_o & {5'h00, rows[i].m});
			if (rows[i].rm)
				chk("result", rows[i].r, result_o);
		end
		bus(1, 8'h03, 8'h00);
		chk("bus write", 8'h18, status_o);
		bus(1, 8'h03, 8'hA2);
		chk("bus write", 8'hBA, status_o);
		chk("pages", 8'h05, {5'h00, indirect_page_o, direct_page_o});
		bus(0, 8'h03, 8'h00);
		chk("read", 8'hBA, rdata_o);
		bus(0, 8'h10, 8'h00);
		chk("read other", 8'h00, rdata_o);
		ev(0, 0, 1);
		chk("timeout", 8'hAA, status_o);
		ins(status_pkg::OP_WIPE, 8'h00, 8'h00, 1'b1);
		chk("wipe", 8'h0E, status_o);
		ev(1, 0, 0);
		chk("kick", 8'h1E, status_o);
		ev(0, 1, 0);
		chk("sleep", 8'h16, status_o);
		ins(status_pkg::OP_ADD, 8'hE0, 8'h27, 1'b1);
		chk("add to status", 8'h11, status_o);
		ins(status_pkg::OP_STORE, 8'h02, 8'h02, 1'b1);
		chk("store to status", 8'h12, status_o);
		@(posedge mclk_i);
		reset_n_i <= 0;
		@(posedge mclk_i);
		reset_n_i <= 1;
		#1;
		chk("second reset", 8'h18, status_o);
		results();
	end
endmodule : tb
